/* File: design/prs_top.sv */
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module prs_top (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire prs_pkg::prs_cmd_t cmd_in,
    input wire prs_pkg::prs_axi_wreq_t axi_wreq_in,
    output prs_pkg::prs_axi_wrsp_t axi_wrsp_out,
    input wire prs_pkg::prs_axi_rreq_t axi_rreq_in,
    output prs_pkg::prs_axi_rrsp_t axi_rrsp_out,
    output logic [prs_pkg::DQ_W-1:0] dq_out,
    output logic dq_valid_out,
    output logic dq_oe_n_out,
    output logic mode_active_out
);

    typedef struct packed {
        logic [31:0] ctrl;
        logic [3:0][7:0] locs;
        logic mode_on;
        logic page_ok;
        logic [7:0] rd_count;
        prs_pkg::prs_line_t [prs_pkg::LINE_DEPTH-1:0] line;
        logic bst_active;
        logic [2:0] bst_beat;
        logic [1:0] bst_loc;
        logic [prs_pkg::DQ_W-1:0] dq;
        logic dq_oe_n;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        prs_pkg::prs_axi_wrsp_t wrsp;
        prs_pkg::prs_axi_rrsp_t rrsp;
    } prs_state_t;

    // =========================================
    // Reset release
    // =========================================
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    // =========================================
    // Read latency and burst look-ahead
    // =========================================
    prs_state_t st_reg;
    prs_state_t st_next;
    logic [5:0] lat_sum;
    logic [4:0] lat_idx;
    logic head_go;
    logic [1:0] upc_loc;
    logic [2:0] upc_beat;
    logic upc_active;
    logic [prs_pkg::DQ_W-1:0] mux_dq;

    assign lat_sum = {1'b0, st_reg.ctrl[prs_pkg::CTRL_RL_LSB +: prs_pkg::RL_W]}
        + (st_reg.ctrl[prs_pkg::CTRL_PLEN_BIT]
        ? {2'h0, st_reg.ctrl[prs_pkg::CTRL_PAR_LAT_LSB +: prs_pkg::PAR_LAT_W]} : 6'h00);
    assign lat_idx = (lat_sum == 6'h00) ? 5'h00
        : ((lat_sum > 6'h20) ? 5'h1F : 5'(lat_sum - 6'h01));

    // A burst arriving at the head replaces the current one, so reads eight apart chain
    assign head_go = st_reg.line[0].valid;
    assign upc_loc = head_go ? st_reg.line[0].loc : st_reg.bst_loc;
    assign upc_beat = head_go ? 3'h0 : 3'(st_reg.bst_beat + 3'h1);
    assign upc_active = head_go || (st_reg.bst_active && (st_reg.bst_beat != prs_pkg::BEAT_LAST));

    prs_lane_mux u_lane_mux (
        .locs_in(st_reg.locs),
        .start_in(upc_loc),
        .beat_in(upc_beat),
        .org_in(st_reg.ctrl[prs_pkg::CTRL_ORG_LSB +: 2]),
        .dq_out(mux_dq)
    );

    // =========================================
    // Next state
    // =========================================
    always_comb
    begin
        st_next = st_reg;
        for (int i = 0; i < prs_pkg::LINE_DEPTH - 1; i++)
        begin
            st_next.line[i] = st_reg.line[i + 1];
        end
        st_next.line[prs_pkg::LINE_DEPTH - 1] = '0;

        // Command decode; address bits outside the used fields are never looked at
        if (cmd_in.valid)
        begin
            case (cmd_in.op)
                prs_pkg::PRS_OP_MRS:
                begin
                    if (!cmd_in.group_select_bit && (cmd_in.bank == prs_pkg::MODE_THREE_BANK))
                    begin
                        st_next.mode_on = cmd_in.addr[prs_pkg::MODE_THREE_EN_BIT];
                        st_next.page_ok = (cmd_in.addr[1:0] == prs_pkg::PAGE_ZERO);
                    end
                end
                prs_pkg::PRS_OP_RD:
                begin
                    if (st_reg.mode_on)
                    begin
                        st_next.line[lat_idx].valid = 1'b1;
                        st_next.line[lat_idx].loc = cmd_in.bank;
                        st_next.rd_count = 8'(st_reg.rd_count + 8'h01);
                    end
                end
                prs_pkg::PRS_OP_WR:
                begin
                    if (st_reg.mode_on && st_reg.page_ok)
                    begin
                        st_next.locs[cmd_in.bank] = cmd_in.addr[7:0];
                    end
                end
                default:
                begin
                    st_next.rd_count = st_reg.rd_count;
                end
            endcase
        end

        // Output stage
        st_next.bst_active = upc_active;
        st_next.bst_beat = upc_beat;
        st_next.bst_loc = upc_loc;
        st_next.dq = upc_active ? mux_dq : '0;
        st_next.dq_oe_n = !upc_active;

        // Register bus: write address and data may arrive in either order
        if (axi_wreq_in.awvalid && st_reg.wrsp.awready)
        begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = axi_wreq_in.awaddr;
        end
        if (axi_wreq_in.wvalid && st_reg.wrsp.wready)
        begin
            st_next.w_held = 1'b1;
            st_next.wdata = axi_wreq_in.wdata;
            st_next.wstrb = axi_wreq_in.wstrb;
        end
        if (st_reg.wrsp.bvalid && axi_wreq_in.bready)
        begin
            st_next.wrsp.bvalid = 1'b0;
        end
        if (st_reg.aw_held && st_reg.w_held && !st_reg.wrsp.bvalid)
        begin
            st_next.aw_held = 1'b0;
            st_next.w_held = 1'b0;
            st_next.wrsp.bvalid = 1'b1;
            st_next.wrsp.bresp = prs_pkg::RESP_OKAY;
            case (st_reg.aw_addr)
                prs_pkg::ADDR_CTRL:
                begin
                    for (int b = 0; b < 4; b++)
                    begin
                        if (st_reg.wstrb[b])
                        begin
                            st_next.ctrl[8 * b +: 8] = st_reg.wdata[8 * b +: 8];
                        end
                    end
                end
                prs_pkg::ADDR_STATUS, prs_pkg::ADDR_PATTERN:
                begin
                    st_next.wrsp.bresp = prs_pkg::RESP_OKAY;
                end
                default:
                begin
                    st_next.wrsp.bresp = prs_pkg::RESP_SLVERR;
                end
            endcase
        end
        st_next.wrsp.awready = !st_next.aw_held && !st_next.wrsp.bvalid;
        st_next.wrsp.wready = !st_next.w_held && !st_next.wrsp.bvalid;

        // Register bus: reads
        if (st_reg.rrsp.rvalid && axi_rreq_in.rready)
        begin
            st_next.rrsp.rvalid = 1'b0;
        end
        if (axi_rreq_in.arvalid && st_reg.rrsp.arready)
        begin
            st_next.rrsp.rvalid = 1'b1;
            st_next.rrsp.rresp = prs_pkg::RESP_OKAY;
            case (axi_rreq_in.araddr)
                prs_pkg::ADDR_CTRL:
                begin
                    st_next.rrsp.rdata = st_reg.ctrl;
                end
                prs_pkg::ADDR_STATUS:
                begin
                    st_next.rrsp.rdata = '0;
                    st_next.rrsp.rdata[prs_pkg::STAT_MODE_BIT] = st_reg.mode_on;
                    st_next.rrsp.rdata[prs_pkg::STAT_BUSY_BIT] = st_reg.bst_active;
                    st_next.rrsp.rdata[prs_pkg::STAT_PAGE_BIT] = st_reg.page_ok;
                    st_next.rrsp.rdata[prs_pkg::STAT_CNT_LSB +: 8] = st_reg.rd_count;
                end
                prs_pkg::ADDR_PATTERN:
                begin
                    st_next.rrsp.rdata = st_reg.locs;
                end
                default:
                begin
                    st_next.rrsp.rdata = '0;
                    st_next.rrsp.rresp = prs_pkg::RESP_SLVERR;
                end
            endcase
        end
        st_next.rrsp.arready = !st_next.rrsp.rvalid;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.ctrl <= prs_pkg::CTRL_RESET;
            st_reg.locs <= prs_pkg::LOCS_RESET;
            st_reg.page_ok <= 1'b1;
            st_reg.dq_oe_n <= 1'b1;
            st_reg.wrsp.awready <= 1'b1;
            st_reg.wrsp.wready <= 1'b1;
            st_reg.rrsp.arready <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // =========================================
    // Outputs
    // =========================================
    assign axi_wrsp_out = st_reg.wrsp;
    assign axi_rrsp_out = st_reg.rrsp;
    assign dq_out = st_reg.dq;
    assign dq_valid_out = st_reg.bst_active;
    assign dq_oe_n_out = st_reg.dq_oe_n;
    assign mode_active_out = st_reg.mode_on;

    // =========================================
    // Checks
    // =========================================
    function automatic logic [3:0] exp_nib(input logic [3:0][7:0] l, input logic [1:0] s, input logic [2:0] b);
        logic [1:0] p;
        exp_nib = 4'h0;
        for (int k = 0; k < 4; k++)
        begin
            p = s + k[1:0];
            exp_nib[k] = l[p][b];
        end
    endfunction

    logic rd_take;
    logic wr_take;
    assign rd_take = cmd_in.valid && (cmd_in.op == prs_pkg::PRS_OP_RD) && st_reg.mode_on;
    assign wr_take = cmd_in.valid && (cmd_in.op == prs_pkg::PRS_OP_WR) && st_reg.mode_on && st_reg.page_ok;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n);

    a_lane_rotate: assert property (dq_valid_out |->
        dq_out[3:0] == exp_nib($past(st_reg.locs), st_reg.bst_loc, st_reg.bst_beat))
        else $error("Lane rotation wrong");
    a_burst_no_gap: assert property (dq_valid_out && (st_reg.bst_beat != prs_pkg::BEAT_LAST) |=>
        dq_valid_out)
        else $error("Gap inside burst");
    a_chain_bursts: assert property (dq_valid_out && (st_reg.bst_beat == prs_pkg::BEAT_LAST) && head_go |=>
        dq_valid_out && (st_reg.bst_beat == 3'h0))
        else $error("Bubble between bursts");
    a_byte_repeat: assert property (dq_valid_out && (st_reg.ctrl[1:0] != prs_pkg::ORG_X4) |->
        dq_out[7:4] == dq_out[3:0])
        else $error("Upper nibble differs");
    a_word_repeat: assert property (dq_valid_out && (st_reg.ctrl[1:0] == prs_pkg::ORG_X16) |->
        dq_out[15:8] == dq_out[7:0])
        else $error("Upper byte differs");
    a_beat_order: assert property (dq_valid_out && !head_go && (st_reg.bst_beat != prs_pkg::BEAT_LAST) |=>
        st_reg.bst_beat == 3'($past(st_reg.bst_beat) + 3'h1))
        else $error("Beat order broken");
    a_read_queue: assert property (rd_take |=>
        st_reg.line[$past(lat_idx)].valid && (st_reg.line[$past(lat_idx)].loc == $past(cmd_in.bank)))
        else $error("Read not queued at its latency");
    a_head_start: assert property (head_go |=> dq_valid_out && (st_reg.bst_beat == 3'h0)
        && (st_reg.bst_loc == $past(st_reg.line[0].loc)))
        else $error("Burst did not start from head");
    a_write_store: assert property (wr_take |=>
        st_reg.locs[$past(cmd_in.bank)] == $past(cmd_in.addr[7:0]))
        else $error("Pattern write not stored");
    a_mode_exit: assert property (cmd_in.valid && (cmd_in.op == prs_pkg::PRS_OP_MRS)
        && !cmd_in.group_select_bit && (cmd_in.bank == prs_pkg::MODE_THREE_BANK)
        && !cmd_in.addr[prs_pkg::MODE_THREE_EN_BIT] |=> !mode_active_out ##1 !st_reg.line[lat_idx].valid)
        else $error("Pattern mode not left");

    // =========================================
    // Mode entry, refused commands, unused lanes and output enable
    // =========================================
    a_mode_enter: assert property (cmd_in.valid && (cmd_in.op == prs_pkg::PRS_OP_MRS)
        && !cmd_in.group_select_bit && (cmd_in.bank == prs_pkg::MODE_THREE_BANK)
        && cmd_in.addr[prs_pkg::MODE_THREE_EN_BIT] |=> mode_active_out)
        else $error("Pattern mode not entered");
    a_read_refused: assert property (cmd_in.valid && (cmd_in.op == prs_pkg::PRS_OP_RD)
        && !st_reg.mode_on |=> st_reg.rd_count == $past(st_reg.rd_count))
        else $error("Read taken outside pattern mode");
    a_write_refused: assert property (cmd_in.valid && (cmd_in.op == prs_pkg::PRS_OP_WR)
        && !(st_reg.mode_on && st_reg.page_ok) |=> $stable(st_reg.locs))
        else $error("Write stored outside pattern mode");
    a_x4_upper_off: assert property (dq_valid_out && (st_reg.ctrl[1:0] == prs_pkg::ORG_X4) |->
        dq_out[15:4] == 12'h000)
        else $error("Unused lanes driven in x4");
    a_x8_upper_off: assert property (dq_valid_out && (st_reg.ctrl[1:0] == prs_pkg::ORG_X8) |->
        dq_out[15:8] == 8'h00)
        else $error("Unused lanes driven in x8");
    a_idle_lanes: assert property (!dq_valid_out |->
        (dq_out == 16'h0000) && dq_oe_n_out)
        else $error("Lanes driven outside a burst");
    a_oe_match: assert property (dq_valid_out |->
        !dq_oe_n_out)
        else $error("Output enable off during a burst");

    c_back_to_back: cover property (dq_valid_out && (st_reg.bst_beat == prs_pkg::BEAT_LAST) ##1
        dq_valid_out && (st_reg.bst_beat == 3'h0));
    c_wide_read: cover property (dq_valid_out && (st_reg.ctrl[1:0] == prs_pkg::ORG_X16));
    c_write_read: cover property (wr_take ##[1:40] dq_valid_out);
    c_exit: cover property (mode_active_out ##1 !mode_active_out);
    c_parity_read: cover property (rd_take && st_reg.ctrl[prs_pkg::CTRL_PLEN_BIT]);

endmodule

/* File: design/prs_pkg.sv */
// Functional notes
// - A staggered read to location N drives lane k with location (N+k) mod 4 for lanes 0 to 3.
// - Reads issued eight clocks apart come out as one unbroken stream with no idle beat between bursts.
// - In byte-wide mode lanes 4 to 7 repeat the rotated pattern of lanes 0 to 3.
// - In sixteen-lane mode lanes 8 to 15 repeat the pattern of lanes 0 to 7.
// - The controller drives column bit 2 low and the eight beats come out in order 0 to 7.
// - The two bank-select inputs pick which of the four locations a read or write uses.
// - Auto-precharge, group select and other unused address bits are ignored during pattern access.
// - Writing zero to the pattern-enable bit of mode register three leaves pattern mode.
// - With parity latency enabled, that latency is added to the read-to-data delay.
// - A pattern write takes its eight data bits from address bits 7 to 0 into the chosen location.
// - Address bit b of a write becomes burst beat b of that location on later reads.
package prs_pkg;

    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PATTERN = 8'h08;
    localparam int CTRL_ORG_LSB = 0;
    localparam int CTRL_PLEN_BIT = 2;
    localparam int CTRL_PAR_LAT_LSB = 4;
    localparam int CTRL_RL_LSB = 8;
    localparam int PAR_LAT_W = 4;
    localparam int RL_W = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0502;
    localparam int STAT_MODE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_PAGE_BIT = 2;
    localparam int STAT_CNT_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Lane organisation
    localparam logic [1:0] ORG_X4 = 2'h0;
    localparam logic [1:0] ORG_X8 = 2'h1;
    localparam logic [1:0] ORG_X16 = 2'h2;

    // Pattern locations after reset
    localparam logic [31:0] LOCS_RESET = 32'h0FF0_3CA5;

    // Mode register three selection
    localparam logic [1:0] MODE_THREE_BANK = 2'h3;
    localparam int MODE_THREE_EN_BIT = 2;
    localparam logic [1:0] PAGE_ZERO = 2'h0;

    // Burst and read pipeline
    localparam logic [2:0] BEAT_LAST = 3'h7;
    localparam int LINE_DEPTH = 32;
    localparam int DQ_W = 16;

    typedef enum logic [1:0] {PRS_OP_NOP, PRS_OP_RD, PRS_OP_WR, PRS_OP_MRS} prs_op_t;

    typedef struct packed {
        logic valid;
        prs_op_t op;
        logic group_select_bit;
        logic [1:0] bank;
        logic [13:0] addr;
    } prs_cmd_t;

    typedef struct packed {
        logic valid;
        logic [1:0] loc;
    } prs_line_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
    } prs_axi_wreq_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
    } prs_axi_wrsp_t;

    typedef struct packed {
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } prs_axi_rreq_t;

    typedef struct packed {
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } prs_axi_rrsp_t;

endpackage

/* File: design/prs_lane_mux.sv */
`timescale 1ns/1ns
module prs_lane_mux (
    input wire logic [3:0][7:0] locs_in,
    input wire logic [1:0] start_in,
    input wire logic [2:0] beat_in,
    input wire logic [1:0] org_in,
    output logic [prs_pkg::DQ_W-1:0] dq_out
);

    // =========================================
    // Per-lane rotated source selection
    // =========================================
    genvar k;
    generate
        for (k = 0; k < prs_pkg::DQ_W; k++)
        begin : g_lane
            logic [1:0] src;
            logic en;
            assign src = start_in + 2'(k % 4);
            assign en = (k < 4) || ((k < 8) && (org_in != prs_pkg::ORG_X4))
                || (org_in == prs_pkg::ORG_X16);
            assign dq_out[k] = en & locs_in[src][beat_in];
        end
    endgenerate

endmodule

/* File: tb/prs_ctrl_model.sv */
`timescale 1ns/1ns
// ====
// Controller model: one command per call
module prs_ctrl_model (
    input wire logic clk_in,
    output prs_pkg::prs_cmd_t cmd_out
);
    initial cmd_out = '0;

    // After the command cycle the bus shows the inverse of its last value
    task automatic issue(input prs_pkg::prs_op_t op, input logic gsel, input logic [1:0] bank,
        input logic [13:0] addr, input int gap);
        prs_pkg::prs_cmd_t idle;
        begin
            @(posedge clk_in);
            cmd_out <= '{1'h1, op, gsel, bank, addr};
            @(posedge clk_in);
            idle = ~cmd_out;
            idle.valid = 1'h0;
            cmd_out <= idle;
            repeat (gap) @(posedge clk_in);
        end
    endtask

    // Column bits 2:0 low, burst-chop and every ignored bit high, reads eight clocks apart
    task automatic rd(input logic [1:0] bank);
        issue(prs_pkg::PRS_OP_RD, 1'h1, bank, 14'h3FF8, 6);
    endtask

    task automatic wr(input logic [1:0] bank, input logic [7:0] data);
        issue(prs_pkg::PRS_OP_WR, 1'h1, bank, {6'h3F, data}, 1);
    endtask

    // Mode register three with page zero
    task automatic mrs(input logic en);
        issue(prs_pkg::PRS_OP_MRS, 1'h0, prs_pkg::MODE_THREE_BANK, {11'h000, en, prs_pkg::PAGE_ZERO}, 3);
    endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic clk;
    logic rst_n;
    prs_pkg::prs_cmd_t cmd;
    prs_pkg::prs_axi_wreq_t wq;
    prs_pkg::prs_axi_wrsp_t ws;
    prs_pkg::prs_axi_rreq_t rq;
    prs_pkg::prs_axi_rrsp_t rs;
    logic [15:0] dq;
    logic dq_valid;
    logic dq_oe_n;
    logic mode_on;
    int bad_count = 0;
    int total_checks = 0;
    int lat = 5;
    logic [1:0] org = prs_pkg::ORG_X16;
    logic [3:0][7:0] locs = prs_pkg::LOCS_RESET;
    logic [31:0] wdat = 32'hC35A_E718;

    prs_top i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .cmd_in(cmd), .axi_wreq_in(wq), .axi_wrsp_out(ws),
        .axi_rreq_in(rq), .axi_rrsp_out(rs), .dq_out(dq), .dq_valid_out(dq_valid), .dq_oe_n_out(dq_oe_n),
        .mode_active_out(mode_on));
    prs_ctrl_model i_ctrl (.clk_in(clk), .cmd_out(cmd));

    // ====
    // Clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // ====
    // Checking
    task tally(input logic ok, input string what);
        begin
            total_checks++;
            if (!ok)
            begin
                bad_count++;
                $display("[FAIL] %0t %s", $time, what);
            end
        end
    endtask
    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tally(got === exp, $sformatf("register %h expected %h", got, exp));
    endtask
    task chk_dq(input logic [15:0] got, input logic [15:0] exp);
        tally(got === exp, $sformatf("lanes %h expected %h", got, exp));
    endtask
    task chk_bit(input logic got, input logic exp);
        tally(got === exp, $sformatf("flag %b expected %b", got, exp));
    endtask

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    // ====
    // Register bus
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        begin
            @(posedge clk);
            wq <= '{1'h1, a, 1'h1, d, 4'hF, 1'h1};
            forever
            begin
                @(posedge clk);
                if (ws.bvalid)
                    break;
                if (ws.awready)
                    wq.awvalid <= 1'h0;
                if (ws.wready)
                    wq.wvalid <= 1'h0;
            end
            wq <= '0;
            chk_reg(32'(ws.bresp), 32'(er));
        end
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        begin
            @(posedge clk);
            rq <= '{1'h1, a, 1'h1};
            forever
            begin
                @(posedge clk);
                if (rs.rvalid)
                    break;
                if (rs.arready)
                    rq.arvalid <= 1'h0;
            end
            d = rs.rdata;
            r = rs.rresp;
            rq <= '0;
        end
    endtask

    task reg_is(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        begin
            axi_rd(a, d, r);
            chk_reg(d, exp);
            chk_reg(32'(r), 32'(er));
        end
    endtask

    // ====
    // Data lanes
    function automatic logic [15:0] expect_dq(input logic [1:0] b, input int beat);
        logic [1:0] src;
        begin
            expect_dq = '0;
            for (int k = 0; k < 16; k++)
            begin
                src = b + 2'(k % 4);
                if (k < 4 || (k < 8 && org != prs_pkg::ORG_X4) || org == prs_pkg::ORG_X16)
                    expect_dq[k] = locs[src][beat];
            end
        end
    endfunction

    task quiet(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            chk_bit(dq_valid, 1'h0);
        end
    endtask

    // Reads eight clocks apart starting at location b0, checked beat by beat
    task burst(input logic [1:0] b0, input int n);
        fork
            for (int i = 0; i < n; i++)
                i_ctrl.rd(b0 + 2'(i));
            begin
                @(posedge clk);
                repeat (lat) @(posedge clk);
                for (int j = 0; j < 8 * n; j++)
                begin
                    @(posedge clk);
                    #1;
                    chk_bit(dq_valid, 1'h1);
                    chk_bit(dq_oe_n, 1'h0);
                    chk_dq(dq, expect_dq(b0 + 2'(j / 8), j % 8));
                end
                @(posedge clk);
                #1;
                chk_bit(dq_oe_n, 1'h1);
                chk_dq(dq, 16'h0000);
            end
        join
    endtask

    // ====
    // Tests
    initial
    begin
        rst_n = 1'h0;
        wq = '0;
        rq = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        chk_bit(mode_on, 1'h0);
        chk_bit(dq_oe_n, 1'h1);
        reg_is(prs_pkg::ADDR_CTRL, prs_pkg::CTRL_RESET, prs_pkg::RESP_OKAY);
        reg_is(prs_pkg::ADDR_PATTERN, prs_pkg::LOCS_RESET, prs_pkg::RESP_OKAY);
        reg_is(prs_pkg::ADDR_STATUS, 32'h0000_0004, prs_pkg::RESP_OKAY);
        reg_is(8'h10, 32'h0000_0000, prs_pkg::RESP_SLVERR);
        axi_wr(8'h10, 32'hFFFF_FFFF, prs_pkg::RESP_SLVERR);
        fork
            i_ctrl.rd(2'h1);
            quiet(14);
        join
        $display("test reset_and_idle done");
        i_ctrl.mrs(1'h1);
        #1;
        chk_bit(mode_on, 1'h1);
        for (int i = 0; i < 3; i++)
        begin
            org = 2'(2 - i);
            axi_wr(prs_pkg::ADDR_CTRL, 32'h0000_0500 | 32'(org), prs_pkg::RESP_OKAY);
            burst(2'(i), 8 - 2 * i);
        end
        $display("test stagger_orgs done");
        axi_wr(prs_pkg::ADDR_CTRL, 32'h0000_0502, prs_pkg::RESP_OKAY);
        org = prs_pkg::ORG_X16;
        for (int b = 0; b < 4; b++)
            i_ctrl.wr(2'(b), wdat[b * 8 +: 8]);
        locs = wdat;
        reg_is(prs_pkg::ADDR_PATTERN, wdat, prs_pkg::RESP_OKAY);
        burst(2'h1, 4);
        $display("test pattern_write done");
        axi_wr(prs_pkg::ADDR_CTRL, 32'h0000_0536, prs_pkg::RESP_OKAY);
        lat = 8;
        burst(2'h2, 2);
        axi_wr(prs_pkg::ADDR_CTRL, 32'h0000_0532, prs_pkg::RESP_OKAY);
        lat = 5;
        burst(2'h3, 2);
        $display("test parity_latency done");
        i_ctrl.mrs(1'h0);
        #1;
        chk_bit(mode_on, 1'h0);
        fork
            i_ctrl.rd(2'h0);
            quiet(14);
        join
        i_ctrl.wr(2'h0, 8'h00);
        reg_is(prs_pkg::ADDR_PATTERN, wdat, prs_pkg::RESP_OKAY);
        reg_is(prs_pkg::ADDR_STATUS, 32'h0000_1A04, prs_pkg::RESP_OKAY);
        $display("test mode_exit done");
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule
